// [aabx_pkg.sv]
// aabx_pkg: constants, opcodes and quarter states for the add-and-branch executor
// Behaviour
// - literal add: accumulator plus literal into accumulator
// - file add: accumulator plus addressed byte
// - destination bit picks accumulator or file byte
// - bank bit picks access bank or bank pointer
// - carry add: accumulator, carry and file byte
// - literal and: accumulator and literal into accumulator
// - file and: accumulator and file byte, routed
// - and updates only negative and zero flags
// - carry branch taken when carry is one
// - taken target is address plus two plus 2n
// - taken branch two cycles, second is idle
// - quarters: decode, read, process, write
package aabx_pkg;
  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] AABX_OP_ADD_LIT = 8'h0f;
  localparam logic [7:0] AABX_OP_AND_LIT = 8'h0b;
  localparam logic [7:0] AABX_OP_BR_CARRY = 8'he2;
  localparam logic [5:0] AABX_OP_ADD_FILE = 6'h09;
  localparam logic [5:0] AABX_OP_ADDC_FILE = 6'h08;
  localparam logic [5:0] AABX_OP_AND_FILE = 6'h05;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int AABX_DEST_BIT = 9;
  localparam int AABX_BANK_BIT = 8;
  // access bank: low half maps to bank 0, high half to bank 15
  localparam logic [7:0] AABX_ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] AABX_ACCESS_HI_BANK = 4'hf;
  localparam logic [3:0] AABX_ACCESS_LO_BANK = 4'h0;
  // ----------------------------------------------------------------
  // reset values and steps
  // ----------------------------------------------------------------
  localparam logic [7:0] AABX_ACC_RESET = 8'h00;
  localparam logic [20:0] AABX_PC_RESET = 21'h000000;
  localparam logic [20:0] AABX_PC_STEP = 21'h000002;
  // ----------------------------------------------------------------
  // quarter-cycle states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {AABX_Q1, AABX_Q2, AABX_Q3, AABX_Q4} aabx_quarter_t;
endpackage : aabx_pkg

// [aabx_alu.sv]
// aabx_alu: 8-bit adder and and unit with status flag generation
`timescale 1ns/1ps
module aabx_alu
(
  // operands
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  input wire logic i_cin,
  input wire logic i_is_and,
  // results
  output logic [7:0] o_res,
  output logic o_carry,
  output logic o_half,
  output logic o_excess,
  output logic o_neg,
  output logic o_zero
);
  logic [8:0] sum;
  logic [4:0] low;
  // sum and nibble carry
  always_comb
  begin
    sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_cin};
    low = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
    o_res = i_is_and ? (i_a & i_b) : sum[7:0];
    o_carry = sum[8];
    o_half = low[4];
    o_excess = (i_a[7] == i_b[7]) && (sum[7] != i_a[7]);
    o_neg = o_res[7];
    o_zero = (o_res == 8'h00);
  end
endmodule : aabx_alu

// [aabx_exec.sv]
// aabx_exec: quarter-cycle decoder and executor for add, and and carry branch
`timescale 1ns/1ps
module aabx_exec
  import aabx_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // instruction fetch
  input wire logic [15:0] i_instr,
  // data memory read data and bank pointer
  input wire logic [7:0] i_file_rdata,
  input wire logic [3:0] i_bank_pointer_reg,
  // data memory access
  output logic [11:0] o_file_addr,
  output logic o_file_rd,
  output logic o_file_wr,
  output logic [7:0] o_file_wdata,
  // core state
  output logic [7:0] o_acc,
  output logic [20:0] o_program_counter,
  output logic o_carry_flag,
  output logic o_half_carry_flag,
  output logic o_zero_flag,
  output logic o_signed_excess_flag,
  output logic o_negative_flag,
  // status
  output logic o_quarter_q1,
  output logic o_branch_idle
);
  import aabx_pkg::*;

  // quarter state, held word and staged result
  aabx_quarter_t quarter;
  logic [15:0] ir;
  logic [7:0] operand;
  logic [7:0] res;

  // staged flags from the process quarter
  logic res_c;
  logic res_dc;
  logic res_ov;
  logic res_n;
  logic res_z;

  // decoded operation of the held word
  logic add_literal_op;
  logic and_literal_op;
  logic branch_on_carry_op;
  logic add_to_file_op;
  logic add_carry_to_file_op;
  logic and_file_op;
  logic file_op;
  logic is_and;
  logic is_add;
  logic dest_file;

  // decode of the word on the fetch port
  logic fetch_file_op;
  logic [3:0] fetch_bank;

  // fetch slot, write slot and taken branch
  logic fetch_slot;
  logic write_slot;
  logic branch_taken;

  // arithmetic unit outputs
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_ov;
  logic alu_n;
  logic alu_z;

  // branch target
  logic [20:0] next_pc_taken;

  // ----------------------------------------------------------------
  // decode of the latched word
  // ----------------------------------------------------------------
  // opcode match on held instruction word
  assign add_literal_op = (ir[15:8] == AABX_OP_ADD_LIT);
  assign and_literal_op = (ir[15:8] == AABX_OP_AND_LIT);
  assign branch_on_carry_op = (ir[15:8] == AABX_OP_BR_CARRY);
  assign add_to_file_op = (ir[15:10] == AABX_OP_ADD_FILE);
  assign add_carry_to_file_op = (ir[15:10] == AABX_OP_ADDC_FILE);
  assign and_file_op = (ir[15:10] == AABX_OP_AND_FILE);
  assign file_op = add_to_file_op | add_carry_to_file_op | and_file_op;
  assign is_and = and_literal_op | and_file_op;
  assign is_add = add_literal_op | add_to_file_op | add_carry_to_file_op;
  assign dest_file = ir[AABX_DEST_BIT];
  // the read address must stand in q2, before the word reaches ir
  assign fetch_file_op = (i_instr[15:10] == AABX_OP_ADD_FILE) ||
    (i_instr[15:10] == AABX_OP_ADDC_FILE) || (i_instr[15:10] == AABX_OP_AND_FILE);
  // bank selection for file operands
  assign fetch_bank = i_instr[AABX_BANK_BIT] ? i_bank_pointer_reg :
    ((i_instr[7:0] >= AABX_ACCESS_SPLIT) ? AABX_ACCESS_HI_BANK : AABX_ACCESS_LO_BANK);
  // a word on the fetch port is taken at this edge, unless refused
  assign fetch_slot = (quarter == AABX_Q1) && !o_branch_idle;
  // results and flags land on the q4 edge of an executed cycle
  assign write_slot = (quarter == AABX_Q4) && !o_branch_idle;
  assign branch_taken = branch_on_carry_op && o_carry_flag;
  // taken target: incremented counter plus twice the signed offset
  assign next_pc_taken = o_program_counter + {{12{ir[7]}}, ir[7:0], 1'b0};

  // ----------------------------------------------------------------
  // arithmetic unit
  // ----------------------------------------------------------------
  aabx_alu u_alu
  (
    .i_a(o_acc),
    .i_b(operand),
    .i_cin(add_carry_to_file_op & o_carry_flag),
    .i_is_and(is_and),
    .o_res(alu_res),
    .o_carry(alu_c),
    .o_half(alu_dc),
    .o_excess(alu_ov),
    .o_neg(alu_n),
    .o_zero(alu_z)
  );

  // ----------------------------------------------------------------
  // quarter sequencer
  // ----------------------------------------------------------------
  // four quarters per instruction cycle
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      quarter <= AABX_Q1;
    else
      case (quarter)
        AABX_Q1: quarter <= AABX_Q2;
        AABX_Q2: quarter <= AABX_Q3;
        AABX_Q3: quarter <= AABX_Q4;
        AABX_Q4: quarter <= AABX_Q1;
        default: quarter <= AABX_Q1;
      endcase
  end

  // ----------------------------------------------------------------
  // branch idle and quarter marker
  // ----------------------------------------------------------------
  // idle second cycle after a taken branch
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_branch_idle <= 1'b0;
    else if (quarter == AABX_Q4)
      o_branch_idle <= !o_branch_idle && branch_taken;
  end

  // marks the first quarter of each cycle
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_quarter_q1 <= 1'b1;
    else
      o_quarter_q1 <= (quarter == AABX_Q4);
  end

  // ----------------------------------------------------------------
  // decode, read, process, write
  // ----------------------------------------------------------------
  // q1 latches the word
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      ir <= 16'h0000;
    else if (quarter == AABX_Q1)
      ir <= i_instr;
  end

  // q2 reads the literal or the file byte
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      operand <= 8'h00;
    else if (quarter == AABX_Q2)
      operand <= file_op ? i_file_rdata : ir[7:0];
  end

  // q3 computes the result
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      res <= 8'h00;
    else if (quarter == AABX_Q3)
      res <= alu_res;
  end

  // q3 stages the flags beside the result
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      {res_c, res_dc, res_ov, res_n, res_z} <= 5'h00;
    else if (quarter == AABX_Q3)
      {res_c, res_dc, res_ov, res_n, res_z} <= {alu_c, alu_dc, alu_ov, alu_n, alu_z};
  end

  // ----------------------------------------------------------------
  // data memory port
  // ----------------------------------------------------------------
  // address taken with the word, held for the read and the write
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_file_addr <= 12'h000;
    else if (quarter == AABX_Q1)
      o_file_addr <= {fetch_bank, i_instr[7:0]};
  end

  // read strobe stands through q2, never for a refused word
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_file_rd <= 1'b0;
    else
      o_file_rd <= fetch_slot && fetch_file_op;
  end

  // write strobe stands through q4 when the destination is the file
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_file_wr <= 1'b0;
    else
      o_file_wr <= (quarter == AABX_Q3) && file_op && dest_file && !o_branch_idle;
  end

  // write data launched with the strobe
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_file_wdata <= 8'h00;
    else if (quarter == AABX_Q3)
      o_file_wdata <= alu_res;
  end

  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  // accumulator write in the fourth quarter
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_acc <= AABX_ACC_RESET;
    else if (write_slot && (add_literal_op || and_literal_op || (file_op && !dest_file)))
      o_acc <= res;
  end

  // ----------------------------------------------------------------
  // status flags: adds set five, and sets two
  // ----------------------------------------------------------------
  // carry out of the adder, kept by and
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_carry_flag <= 1'b0;
    else if (write_slot && is_add)
      o_carry_flag <= res_c;
  end

  // nibble carry of the adder, kept by and
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_half_carry_flag <= 1'b0;
    else if (write_slot && is_add)
      o_half_carry_flag <= res_dc;
  end

  // signed overflow of the adder, kept by and
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_signed_excess_flag <= 1'b0;
    else if (write_slot && is_add)
      o_signed_excess_flag <= res_ov;
  end

  // negative from bit 7 of any add or and result
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_negative_flag <= 1'b0;
    else if (write_slot && (is_add || is_and))
      o_negative_flag <= res_n;
  end

  // zero from any add or and result
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_zero_flag <= 1'b0;
    else if (write_slot && (is_add || is_and))
      o_zero_flag <= res_z;
  end

  // ----------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------
  // step per word, branch target on taken carry branch
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_program_counter <= AABX_PC_RESET;
    else if (fetch_slot)
      o_program_counter <= o_program_counter + AABX_PC_STEP;
    else if (write_slot && branch_taken)
      o_program_counter <= next_pc_taken;
  end
endmodule : aabx_exec

// [aabx_mem_model.sv]
// aabx_mem_model: banked data memory facing the executor
`timescale 1ns/1ps
module aabx_mem_model
(
  // clock
  input wire logic i_clk,
  // access from the executor
  input wire logic [11:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  // read data
  output logic [7:0] o_rdata
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [7:0] mem [4096];
  // stored byte while read, inverted byte otherwise
  assign o_rdata = i_rd ? mem[i_addr] : ~mem[i_addr];
  // byte write on the strobe
  always @(posedge i_clk)
    if (i_wr) mem[i_addr] <= i_wdata;
endmodule : aabx_mem_model

// [aabx_exec_properties.sv]
// aabx_exec_properties: timing checks on the executor ports
`timescale 1ns/1ps
module aabx_exec_properties
  import aabx_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // watched ports
  input wire logic [15:0] i_instr,
  input wire logic o_file_rd,
  input wire logic o_file_wr,
  input wire logic [7:0] o_acc,
  input wire logic [20:0] o_program_counter,
  input wire logic o_carry_flag,
  input wire logic o_half_carry_flag,
  input wire logic o_signed_excess_flag,
  input wire logic o_quarter_q1,
  input wire logic o_branch_idle
);
  // ------------------------------------------------------------
  // decode helpers and checks
  // ------------------------------------------------------------
  logic go, fop, br, and_op;
  logic [7:0] lit;
  logic [2:0] kept;
  logic [20:0] ofs;
  // a word is taken on this edge
  assign go = o_quarter_q1 && !o_branch_idle;
  assign fop = i_instr[15:10] inside {AABX_OP_ADD_FILE, AABX_OP_ADDC_FILE, AABX_OP_AND_FILE};
  assign br = go && i_instr[15:8] == AABX_OP_BR_CARRY;
  assign and_op = i_instr[15:10] == AABX_OP_AND_FILE || i_instr[15:8] == AABX_OP_AND_LIT;
  assign lit = i_instr[7:0];
  assign kept = {o_carry_flag, o_half_carry_flag, o_signed_excess_flag};
  assign ofs = {{12{i_instr[7]}}, i_instr[7:0], 1'b0};
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  chk_rd_second_quarter: assert property (go && fop |=> o_file_rd)
    else $error("file read missing in second quarter");
  chk_wr_fourth_quarter: assert property (go && fop && i_instr[AABX_DEST_BIT] |-> ##3 o_file_wr ##1 !o_file_wr)
    else $error("file write strobe misplaced");
  chk_pc_step: assert property (go |=> o_program_counter == $past(o_program_counter) + AABX_PC_STEP)
    else $error("program counter did not step");
  chk_taken_idle: assert property (br && o_carry_flag |-> ##4 o_branch_idle [*4])
    else $error("taken branch lacks idle cycle");
  chk_not_taken: assert property (br && !o_carry_flag |-> ##4 !o_branch_idle && o_program_counter == $past(o_program_counter, 4) + AABX_PC_STEP)
    else $error("untaken branch misbehaved");
  chk_branch_target: assert property (br && o_carry_flag |-> ##4 o_program_counter == $past(o_program_counter, 4) + AABX_PC_STEP + $past(ofs, 4))
    else $error("branch target wrong");
  chk_and_flags_kept: assert property (go && and_op |-> ##4 kept == $past(kept, 4))
    else $error("and changed carry flags");
  chk_lit_add_sum: assert property (go && i_instr[15:8] == AABX_OP_ADD_LIT |-> ##4 o_acc == $past(o_acc, 4) + $past(lit, 4))
    else $error("literal add sum wrong");
  // main scenarios
  cov_taken: cover property (br && o_carry_flag);
  cov_untaken: cover property (br && !o_carry_flag);
  cov_file_wr: cover property (o_file_wr);
endmodule : aabx_exec_properties
bind aabx_exec aabx_exec_properties u_aabx_exec_properties (.i_clk, .i_srst, .i_instr,
  .o_file_rd, .o_file_wr, .o_acc, .o_program_counter, .o_carry_flag, .o_half_carry_flag,
  .o_signed_excess_flag, .o_quarter_q1, .o_branch_idle);

// [testbench.sv]
// testbench: self-checking scenarios for the executor
`timescale 1ns/1ps
module testbench;
  import aabx_pkg::*;
  logic i_clk = 1'b0, i_srst = 1'b1;
  logic [15:0] i_instr = 16'h0000;
  logic [3:0] i_bank_pointer_reg = 4'h3;
  logic [7:0] i_file_rdata, o_file_wdata, o_acc, acc;
  logic [11:0] o_file_addr;
  logic [20:0] o_program_counter, pc;
  logic o_file_rd, o_file_wr, o_carry_flag, o_half_carry_flag, o_zero_flag;
  logic o_signed_excess_flag, o_negative_flag, o_quarter_q1, o_branch_idle;
  logic c, dc, z, ov, n;
  int num_errors = 0, samples_checked = 0;
  // ------------------------------------------------------------
  // design, partner and tasks
  // ------------------------------------------------------------
  aabx_exec u_aabx_exec (.i_clk, .i_srst, .i_instr, .i_file_rdata, .i_bank_pointer_reg,
    .o_file_addr, .o_file_rd, .o_file_wr, .o_file_wdata, .o_acc, .o_program_counter,
    .o_carry_flag, .o_half_carry_flag, .o_zero_flag, .o_signed_excess_flag,
    .o_negative_flag, .o_quarter_q1, .o_branch_idle);
  aabx_mem_model u_aabx_mem_model (.i_clk, .i_addr(o_file_addr), .i_rd(o_file_rd),
    .i_wr(o_file_wr), .i_wdata(o_file_wdata), .o_rdata(i_file_rdata));
  // 100 MHz clock
  always #5 i_clk = ~i_clk;
  task finish_test;
    if (num_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // bounded wait for an edge that takes a word
  task go_q1;
    int k;
    k = 0;
    while (!(o_quarter_q1 === 1'b1 && o_branch_idle === 1'b0) && k < 16)
    begin
      @(negedge i_clk);
      k++;
    end
    if (!(o_quarter_q1 === 1'b1 && o_branch_idle === 1'b0))
    begin
      num_errors++;
      finish_test();
    end
  endtask : go_q1
  // one add or and word with operand b, file byte at ea
  task step(input logic [15:0] w, input logic [7:0] b, input logic [11:0] ea);
    logic f, wb, ci;
    logic [8:0] s;
    logic [7:0] r;
    f = w[15:12] != 4'h0;
    wb = f && w[AABX_DEST_BIT];
    ci = (w[15:10] == AABX_OP_ADDC_FILE) && c;
    s = {1'b0, acc} + b + ci;
    r = s[7:0];
    if (w[15:10] == AABX_OP_AND_FILE || w[15:8] == AABX_OP_AND_LIT) r = acc & b;
    else
    begin
      dc = {1'b0, acc[3:0]} + b[3:0] + ci > 5'h0f;
      ov = acc[7] == b[7] && r[7] != acc[7];
      c = s[8];
    end
    n = r[7];
    z = r == 8'h00;
    if (f) u_aabx_mem_model.mem[ea] = b;
    go_q1();
    i_instr = w;
    pc = pc + AABX_PC_STEP;
    @(negedge i_clk);
    if (f) chk(o_file_addr, ea);
    chk(o_file_rd, f);
    repeat (2) @(negedge i_clk);
    chk(o_file_wr, wb);
    if (wb) chk(o_file_wdata, r);
    @(negedge i_clk);
    if (!wb) acc = r;
    chk(o_acc, acc);
    chk({o_carry_flag, o_half_carry_flag, o_zero_flag, o_signed_excess_flag,
      o_negative_flag}, {c, dc, z, ov, n});
    chk(o_program_counter, pc);
  endtask : step
  // carry branch, then a word offered in the idle cycle
  task br(input logic [7:0] off);
    logic t;
    t = c;
    go_q1();
    i_instr = {AABX_OP_BR_CARRY, off};
    pc = pc + AABX_PC_STEP;
    repeat (4) @(negedge i_clk);
    if (t) pc = pc + {{12{off[7]}}, off, 1'b0};
    chk(o_program_counter, pc);
    chk(o_branch_idle, t);
    if (t)
    begin
      i_instr = {AABX_OP_ADD_LIT, 8'h01};
      repeat (4) @(negedge i_clk);
      chk({o_acc, o_program_counter}, {acc, pc});
      chk(o_branch_idle, 1'b0);
    end
  endtask : br
  // main sequence
  initial
  begin
    {acc, pc, c, dc, z, ov, n} = '0;
    repeat (10) @(posedge i_clk);
    @(negedge i_clk);
    chk({o_acc, o_program_counter}, 29'h0);
    i_srst = 1'b0;
    step(16'h0f10, 8'h10, 12'h000);
    step(16'h0f15, 8'h15, 12'h000);
    step(16'h0f5b, 8'h5b, 12'h000);
    step(16'h0f80, 8'h80, 12'h000);
    step(16'h2012, 8'h02, 12'h012);
    step(16'h2734, 8'hff, 12'h334);
    step(16'h0bf0, 8'hf0, 12'h000);
    br(8'h7f);
    step(16'h0f17, 8'h17, 12'h000);
    step(16'h1480, 8'hc2, 12'hf80);
    br(8'h05);
    step(16'h2290, 8'hff, 12'hf90);
    br(8'h80);
    step(16'h2405, 8'h11, 12'h005);
    i_bank_pointer_reg = 4'ha;
    step(16'h1780, 8'h0f, 12'ha80);
    finish_test();
  end
endmodule : testbench
